// ==== design/relay_blocks.sv ====
// basic gates and generic special-function input conventions; inputs sampled per program cycle (invert per clock), timer stepped per hundredth second
`timescale 1ns/10ps
`default_nettype none
`include "relay_blocks_cfg.svh"
module relay_blocks #(
    parameter int N_IN = `GATE_INPUTS,
    parameter int CYCLE_CLKS = (`CYCLE_NS / `CLK_PERIOD_NS < 1) ? 1 : `CYCLE_NS / `CLK_PERIOD_NS,
    parameter int TICK_CLKS = `HUNDREDTH_NS / `CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [N_IN-1:0] nand_in,
    input wire logic [N_IN-1:0] nand_conn,
    input wire logic [N_IN-1:0] nand_inv,
    input wire logic [N_IN-1:0] edge_in,
    input wire logic [N_IN-1:0] edge_conn,
    input wire logic [N_IN-1:0] edge_inv,
    input wire logic [N_IN-1:0] or_in,
    input wire logic [N_IN-1:0] or_conn,
    input wire logic [N_IN-1:0] or_inv,
    input wire logic [N_IN-1:0] nor_in,
    input wire logic [N_IN-1:0] nor_conn,
    input wire logic [N_IN-1:0] nor_inv,
    input wire logic [`XOR_INPUTS-1:0] xor_in,
    input wire logic [`XOR_INPUTS-1:0] xor_conn,
    input wire logic [`XOR_INPUTS-1:0] xor_inv,
    input wire logic not_in,
    input wire logic not_conn,
    input wire logic [`SF_INPUTS-1:0] sf_in,
    input wire logic [`SF_INPUTS-1:0] sf_conn,
    input wire logic [`SF_INPUTS-1:0] sf_inv,
    input wire relay_blocks_pkg::timebase_e sf_timebase,
    input wire logic [`PART_W-1:0] sf_time_hi,
    input wire logic [`PART_W-1:0] sf_time_lo,
    input wire logic sf_retain,
    input wire logic sf_always_retain,
    input wire logic power_restore,
    output logic nand_q,
    output logic edge_q,
    output logic or_q,
    output logic nor_q,
    output logic xor_q,
    output logic not_q,
    output logic sf_q,
    output logic sf_running,
    output logic [`CNT_W-1:0] sf_count
);

    ////////////////////////////////////////////////////////////////////////////////
    // input conditioning

    function automatic logic eff_bit(input logic in, input logic conn, input logic inv,
                                     input logic dflt);
        eff_bit = conn ? (in ^ inv) : dflt;
    endfunction : eff_bit

    function automatic logic [`TIME_W-1:0] time_ticks(input relay_blocks_pkg::timebase_e tb,
                                                       input logic [`PART_W-1:0] hi,
                                                       input logic [`PART_W-1:0] lo);
        logic [`TIME_W-1:0] h;
        logic [`TIME_W-1:0] l;
        h = `TIME_W'(hi);
        l = `TIME_W'(lo);
        unique case (tb)
            relay_blocks_pkg::TB_SECONDS: time_ticks = h * `CENTI_PER_S + l;
            relay_blocks_pkg::TB_MINUTES: time_ticks = h * `CENTI_PER_M + l * `CENTI_PER_S;
            relay_blocks_pkg::TB_HOURS: time_ticks = h * `CENTI_PER_H + l * `CENTI_PER_M;
            default: time_ticks = `TIME_INIT;
        endcase
    endfunction : time_ticks

    logic [N_IN-1:0] nand_eff;
    logic [N_IN-1:0] edge_eff;
    logic [N_IN-1:0] or_eff;
    logic [N_IN-1:0] nor_eff;
    logic [`XOR_INPUTS-1:0] xor_eff;
    logic [`SF_INPUTS-1:0] sf_eff;
    logic not_eff;

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++)
        begin : g_gate_in
            assign nand_eff[gi] = eff_bit(nand_in[gi], nand_conn[gi], nand_inv[gi], 1'b1);
            assign edge_eff[gi] = eff_bit(edge_in[gi], edge_conn[gi], edge_inv[gi], 1'b1);
            assign or_eff[gi] = eff_bit(or_in[gi], or_conn[gi], or_inv[gi], 1'b0);
            assign nor_eff[gi] = eff_bit(nor_in[gi], nor_conn[gi], nor_inv[gi], 1'b0);
        end
        for (gi = 0; gi < `XOR_INPUTS; gi++)
        begin : g_xor_in
            assign xor_eff[gi] = eff_bit(xor_in[gi], xor_conn[gi], xor_inv[gi], 1'b0);
        end
        for (gi = 0; gi < `SF_INPUTS; gi++)
        begin : g_sf_in
            assign sf_eff[gi] = eff_bit(sf_in[gi], sf_conn[gi], sf_inv[gi], 1'b0);
        end
    endgenerate
    assign not_eff = eff_bit(not_in, not_conn, 1'b0, 1'b0);

    ////////////////////////////////////////////////////////////////////////////////
    // program-cycle and hundredth-second enables

    logic [`TIME_W-1:0] cyc_cnt_reg, cyc_cnt_next, tick_cnt_reg, tick_cnt_next;
    logic cycle_en_reg, cycle_en_next, tick_en_reg, tick_en_next;

    always_comb
    begin
        cycle_en_next = (cyc_cnt_reg == `TIME_W'(CYCLE_CLKS - 1));
        cyc_cnt_next = cycle_en_next ? `TIME_INIT : cyc_cnt_reg + `TIME_STEP;
        tick_en_next = (tick_cnt_reg == `TIME_W'(TICK_CLKS - 1));
        tick_cnt_next = tick_en_next ? `TIME_INIT : tick_cnt_reg + `TIME_STEP;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cyc_cnt_reg <= `TIME_INIT;
            tick_cnt_reg <= `TIME_INIT;
            cycle_en_reg <= 1'b0;
            tick_en_reg <= 1'b0;
        end
        else
        begin
            cyc_cnt_reg <= cyc_cnt_next;
            tick_cnt_reg <= tick_cnt_next;
            cycle_en_reg <= cycle_en_next;
            tick_en_reg <= tick_en_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // basic gates

    logic nand_reg, nand_next, edge_reg, edge_next, or_reg, or_next;
    logic nor_reg, nor_next, xor_reg, xor_next, not_reg, not_next;
    logic [N_IN-1:0] edge_prev_reg, edge_prev_next;

    always_comb
    begin
        nand_next = nand_reg;
        edge_next = edge_reg;
        or_next = or_reg;
        nor_next = nor_reg;
        xor_next = xor_reg;
        not_next = not_reg;
        edge_prev_next = edge_prev_reg;
        if (cycle_en_reg)
        begin
            nand_next = ~&nand_eff;
            edge_next = (~&edge_eff) & (&edge_prev_reg);
            edge_prev_next = edge_eff;
            or_next = |or_eff;
            nor_next = ~|nor_eff;
            xor_next = xor_eff[0] ^ xor_eff[1];
            not_next = ~not_eff;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nand_reg <= 1'b1;
            edge_reg <= 1'b0;
            or_reg <= 1'b0;
            nor_reg <= 1'b1;
            xor_reg <= 1'b0;
            not_reg <= 1'b1;
            edge_prev_reg <= '0;
        end
        else
        begin
            nand_reg <= nand_next;
            edge_reg <= edge_next;
            or_reg <= or_next;
            nor_reg <= nor_next;
            xor_reg <= xor_next;
            not_reg <= not_next;
            edge_prev_reg <= edge_prev_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // generic special function: set, clear, trigger timer, up/down counter

    relay_blocks_pkg::sf_state_e state_reg, state_next;
    logic [`TIME_W-1:0] elapsed_reg, elapsed_next;
    logic [`CNT_W-1:0] count_reg, count_next;
    logic q_reg, q_next, sf_q_reg, sf_q_next;
    logic trg_prev_reg, trg_prev_next, cnt_prev_reg, cnt_prev_next;
    logic running_reg, running_next;
    logic forget;

    assign forget = power_restore & ~sf_retain & ~sf_always_retain;

    always_comb
    begin
        state_next = state_reg;
        elapsed_next = elapsed_reg;
        count_next = count_reg;
        q_next = q_reg;
        trg_prev_next = trg_prev_reg;
        cnt_prev_next = cnt_prev_reg;
        if (forget)
        begin
            state_next = relay_blocks_pkg::SF_IDLE;
            elapsed_next = `TIME_INIT;
            count_next = `CNT_INIT;
            q_next = 1'b0;
        end
        else
        begin
            if (tick_en_reg && state_reg == relay_blocks_pkg::SF_RUN && sf_eff[`SF_EN])
            begin
                elapsed_next = elapsed_reg + `TIME_STEP;
                if (elapsed_next >= time_ticks(sf_timebase, sf_time_hi, sf_time_lo))
                begin
                    state_next = relay_blocks_pkg::SF_DONE;
                    q_next = 1'b1;
                end
            end
            if (cycle_en_reg)
            begin
                trg_prev_next = sf_eff[`SF_TRG];
                cnt_prev_next = sf_eff[`SF_CNT];
                if (sf_eff[`SF_CLR_ALL] || sf_eff[`SF_CLR])
                begin
                    state_next = relay_blocks_pkg::SF_IDLE;
                    elapsed_next = `TIME_INIT;
                    count_next = `CNT_INIT;
                    q_next = 1'b0;
                end
                else if (sf_eff[`SF_EN])
                begin
                    if (sf_eff[`SF_SET])
                        q_next = 1'b1;
                    if (sf_eff[`SF_TRG] && !trg_prev_reg)
                    begin
                        state_next = relay_blocks_pkg::SF_RUN;
                        elapsed_next = `TIME_INIT;
                    end
                    if (sf_eff[`SF_CNT] && !cnt_prev_reg)
                        count_next = sf_eff[`SF_DIR] ? count_reg - `CNT_STEP
                                                     : count_reg + `CNT_STEP;
                end
            end
        end
        sf_q_next = (cycle_en_reg && sf_eff[`SF_CLR]) ? 1'b0 : q_next ^ sf_eff[`SF_INV];
        running_next = (state_next == relay_blocks_pkg::SF_RUN);
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= relay_blocks_pkg::SF_IDLE;
            elapsed_reg <= `TIME_INIT;
            count_reg <= `CNT_INIT;
            q_reg <= 1'b0;
            sf_q_reg <= 1'b0;
            running_reg <= 1'b0;
            trg_prev_reg <= 1'b0;
            cnt_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            elapsed_reg <= elapsed_next;
            count_reg <= count_next;
            q_reg <= q_next;
            sf_q_reg <= sf_q_next;
            running_reg <= running_next;
            trg_prev_reg <= trg_prev_next;
            cnt_prev_reg <= cnt_prev_next;
        end
    end

    assign nand_q = nand_reg;
    assign edge_q = edge_reg;
    assign or_q = or_reg;
    assign nor_q = nor_reg;
    assign xor_q = xor_reg;
    assign not_q = not_reg;
    assign sf_q = sf_q_reg;
    assign sf_running = running_reg;
    assign sf_count = count_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_nand_out: assert property (cycle_en_reg |=> nand_q == ~&$past(nand_eff))
        else $error("nand output wrong");
    a_edge_nand: assert property (cycle_en_reg |=>
        edge_q == ((~&$past(edge_eff)) & (&$past(edge_prev_reg))))
        else $error("edge nand output wrong");
    a_or_out: assert property (cycle_en_reg |=> or_q == |$past(or_eff))
        else $error("or output wrong");
    a_nor_out: assert property (cycle_en_reg |=> nor_q == ~|$past(nor_eff))
        else $error("nor output wrong");
    a_xor_out: assert property (cycle_en_reg |=> xor_q == ^$past(xor_eff))
        else $error("xor output wrong");
    a_not_out: assert property (cycle_en_reg |=> not_q == !$past(not_eff))
        else $error("not output wrong");
    a_sf_clear: assert property (cycle_en_reg && sf_eff[`SF_CLR] && !forget
        |=> !sf_q && sf_count == `CNT_INIT && !sf_running)
        else $error("clear did not force inactive");
    a_sf_gated: assert property (cycle_en_reg && !sf_eff[`SF_EN] && !sf_eff[`SF_CLR]
        && !sf_eff[`SF_CLR_ALL] && !forget |=> $stable(sf_count))
        else $error("count moved while gated off");
    a_sf_count_up: assert property (cycle_en_reg && sf_eff[`SF_EN] && !sf_eff[`SF_CLR]
        && !sf_eff[`SF_CLR_ALL] && !forget && sf_eff[`SF_CNT] && !cnt_prev_reg
        && !sf_eff[`SF_DIR] |=> sf_count == $past(sf_count) + `CNT_STEP)
        else $error("count pulse not counted up");
    a_sf_retain: assert property (power_restore && (sf_retain || sf_always_retain)
        && !cycle_en_reg |=> $stable(sf_count))
        else $error("retained count lost");
    a_cycle_gap: assert property (cycle_en_reg && CYCLE_CLKS > 1 |=> !cycle_en_reg)
        else $error("program cycle enable too long");

    c_edge_fire: cover property (edge_q);
    c_timer_done: cover property (state_reg == relay_blocks_pkg::SF_DONE);
    c_count_down: cover property (cycle_en_reg && sf_eff[`SF_DIR] && sf_eff[`SF_CNT]);
    c_forget: cover property (forget);

endmodule : relay_blocks
`default_nettype wire

// ==== design/relay_blocks_cfg.svh ====
// constants for the program-cycle logic function blocks
// How it works
// - nand low only when all inputs high
// - unconnected nand inputs read as one
// - edge nand: one after all-high, now some low
// - or high when any input high
// - unconnected or, nor, xor inputs read zero
// - nor high only when all inputs low
// - xor of two inputs, high when different
// - not outputs complement of single input
// - set input drives function output high
// - clear overrides all but invert, outputs go inactive; with invert high the output is low only one clock per program cycle
// - trigger input starts the function's timer
// - each count pulse is one count event
// - direction input selects up or down counting
// - gate low makes function ignore set, trigger and count inputs; clear, clear-all and invert still act
// - invert input inverts the function's signal
// - clear-all returns every internal value initial
// - unconnected special function inputs read zero
// - time value decoded by selected timebase
// - retentive function keeps state, timing resumes
// - no retention unless explicitly enabled
// - always-retentive function classes keep state always
// - each basic input individually invertible, except the single not input
`ifndef RELAY_BLOCKS_CFG_SVH
`define RELAY_BLOCKS_CFG_SVH
`define GATE_INPUTS 4
`define XOR_INPUTS 2
`define SF_INPUTS 8
`define SF_SET 3'h0
`define SF_CLR 3'h1
`define SF_TRG 3'h2
`define SF_CNT 3'h3
`define SF_DIR 3'h4
`define SF_EN 3'h5
`define SF_INV 3'h6
`define SF_CLR_ALL 3'h7
`define CNT_W 16
`define TIME_W 32
`define PART_W 8
`define CLK_PERIOD_NS 32'h0000_0014
`define CYCLE_NS 32'h0000_03E8
`define HUNDREDTH_NS 32'h0098_9680
`define CENTI_PER_S 32'h0000_0064
`define CENTI_PER_M 32'h0000_1770
`define CENTI_PER_H 32'h0005_7E40
`define CNT_INIT 16'h0000
`define TIME_INIT 32'h0000_0000
`define CNT_STEP 16'h0001
`define TIME_STEP 32'h0000_0001
`endif

// ==== design/relay_blocks_pkg.sv ====
// types shared by the logic function blocks
`default_nettype none
package relay_blocks_pkg;
    typedef enum logic [1:0] {TB_SECONDS, TB_MINUTES, TB_HOURS} timebase_e;
    typedef enum logic [1:0] {SF_IDLE, SF_RUN, SF_DONE} sf_state_e;
endpackage : relay_blocks_pkg
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the logic function blocks
`timescale 1ns/10ps
`default_nettype none
`include "relay_blocks_cfg.svh"
module tb_top;
    localparam logic [7:0] B_SET = 8'h01 << `SF_SET;
    localparam logic [7:0] B_CLR = 8'h01 << `SF_CLR;
    localparam logic [7:0] B_TRG = 8'h01 << `SF_TRG;
    localparam logic [7:0] B_CNT = 8'h01 << `SF_CNT;
    localparam logic [7:0] B_DIR = 8'h01 << `SF_DIR;
    localparam logic [7:0] B_EN = 8'h01 << `SF_EN;
    localparam logic [7:0] B_INV = 8'h01 << `SF_INV;
    localparam logic [7:0] B_ALL = 8'h01 << `SF_CLR_ALL;
    logic ref_clk, rstn, load, power_restore, retain, always_keep, prev_all, q_m;
    logic nand_q, edge_q, or_q, nor_q, xor_q, not_q, sf_q, sf_running;
    logic [55:0] vin, vq;
    logic [7:0] sf_in, sf_conn, t_hi, t_lo;
    logic [`CNT_W-1:0] sf_count;
    relay_blocks_pkg::timebase_e tbase;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    int cnt_m;

    upstream_blocks src (.ref_clk(ref_clk), .rstn(rstn), .load(load), .vec_in(vin), .vec_q(vq));
    relay_blocks #(.CYCLE_CLKS(4), .TICK_CLKS(10)) dut (
        .ref_clk(ref_clk), .rstn(rstn),
        .nand_in(vq[3:0]), .nand_conn(vq[7:4]), .nand_inv(vq[11:8]),
        .edge_in(vq[15:12]), .edge_conn(vq[19:16]), .edge_inv(vq[23:20]),
        .or_in(vq[27:24]), .or_conn(vq[31:28]), .or_inv(vq[35:32]),
        .nor_in(vq[39:36]), .nor_conn(vq[43:40]), .nor_inv(vq[47:44]),
        .xor_in(vq[49:48]), .xor_conn(vq[51:50]), .xor_inv(vq[53:52]),
        .not_in(vq[54]), .not_conn(vq[55]),
        .sf_in(sf_in), .sf_conn(sf_conn), .sf_inv(8'h00), .sf_timebase(tbase),
        .sf_time_hi(t_hi), .sf_time_lo(t_lo), .sf_retain(retain),
        .sf_always_retain(always_keep), .power_restore(power_restore),
        .nand_q(nand_q), .edge_q(edge_q), .or_q(or_q), .nor_q(nor_q), .xor_q(xor_q),
        .not_q(not_q), .sf_q(sf_q), .sf_running(sf_running), .sf_count(sf_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    // effective inputs: xor with invert bit when connected, default level when not
    function automatic logic [5:0] model(input logic [55:0] v);
        logic [3:0] n, e, o, r;
        logic [1:0] x;
        n = ((v[3:0] ^ v[11:8]) & v[7:4]) | ~v[7:4];
        e = ((v[15:12] ^ v[23:20]) & v[19:16]) | ~v[19:16];
        o = (v[27:24] ^ v[35:32]) & v[31:28];
        r = (v[39:36] ^ v[47:44]) & v[43:40];
        x = (v[49:48] ^ v[53:52]) & v[51:50];
        model = {&e, ~&n, |o, ~|r, ^x, ~(v[54] & v[55])};
    endfunction : model

    // one vector held ten clocks; the edge pulse must last exactly one program cycle
    task automatic gate_step(input logic [55:0] v);
        logic [5:0] m;
        int hits;
        m = model(v);
        hits = 0;
        @(posedge ref_clk);
        vin <= v;
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
        repeat (8)
        begin
            @(posedge ref_clk);
            #1;
            hits += int'(edge_q === 1'b1);
        end
        chk1(nand_q, m[4]);
        chk1(or_q, m[3]);
        chk1(nor_q, m[2]);
        chk1(xor_q, m[1]);
        chk1(not_q, m[0]);
        chk1(hits == 4, prev_all && !m[5]);
        prev_all = m[5];
    endtask : gate_step

    task automatic sf_apply(input logic [7:0] bits, input logic [7:0] conn = 8'hFF);
        @(posedge ref_clk);
        sf_in <= bits;
        sf_conn <= conn;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : sf_apply

    task automatic count_pulse(input logic [7:0] extra, input int step);
        sf_apply(extra | B_CNT);
        sf_apply(extra);
        cnt_m += step;
        chk16(sf_count, 16'(cnt_m));
    endtask : count_pulse

    task automatic power_cycle(input logic r, input logic a);
        @(posedge ref_clk);
        retain <= r;
        always_keep <= a;
        power_restore <= 1'b1;
        @(posedge ref_clk);
        power_restore <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        if (!(r || a))
        begin
            cnt_m = 0;
            q_m = 1'b0;
        end
        chk16(sf_count, 16'(cnt_m));
        chk1(sf_q, q_m);
    endtask : power_cycle

    task automatic timer_case(input relay_blocks_pkg::timebase_e b, input logic [7:0] hi,
                              input logic [7:0] lo, input int ticks);
        @(posedge ref_clk);
        tbase <= b;
        t_hi <= hi;
        t_lo <= lo;
        sf_apply(B_EN | B_CLR);
        sf_apply(B_EN | B_TRG);
        chk1(sf_running, 1'b1);
        repeat (ticks * 10 - 28) @(posedge ref_clk);
        #1;
        chk1(sf_running, 1'b1);
        chk1(sf_q, 1'b0);
        repeat (40) @(posedge ref_clk);
        #1;
        chk1(sf_running, 1'b0);
        chk1(sf_q, 1'b1);
    endtask : timer_case

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [3:0] k;
        rstn = 1'b0;
        load = 1'b0;
        vin = 56'h0;
        sf_in = 8'h00;
        sf_conn = 8'hFF;
        tbase = relay_blocks_pkg::TB_SECONDS;
        t_hi = 8'h00;
        t_lo = 8'h00;
        retain = 1'b0;
        always_keep = 1'b0;
        power_restore = 1'b0;
        prev_all = 1'b1;
        q_m = 1'b0;
        cnt_m = 0;
        void'($urandom(98));
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (10) @(posedge ref_clk);
        for (int i = 0; i < 16; i++)
        begin
            k = i[3:0];
            gate_step({1'b1, k[0], 4'h3, k[1:0], 4'h0, 4'hF, k, 4'h0, 4'hF, k,
                       4'h0, 4'hF, k, 4'h0, 4'hF, k});
        end
        repeat (150) gate_step(56'({$urandom(), $urandom()}));
        $display("test gates done");
        sf_apply(B_EN | B_CLR);
        chk1(sf_q, 1'b0);
        sf_apply(B_SET);
        chk1(sf_q, 1'b0);
        sf_apply(B_EN | B_SET | B_CLR);
        chk1(sf_q, 1'b0);
        sf_apply(B_EN | B_SET, ~B_EN);
        chk1(sf_q, 1'b0);
        sf_apply(B_EN | B_SET);
        chk1(sf_q, 1'b1);
        sf_apply(B_EN | B_INV);
        chk1(sf_q, 1'b0);
        q_m = 1'b1;
        for (int j = 0; j < 3; j++)
            count_pulse(B_EN, 1);
        count_pulse(B_EN | B_DIR, -1);
        count_pulse(8'h00, 0);
        power_cycle(1'b1, 1'b0);
        power_cycle(1'b0, 1'b1);
        sf_apply(B_EN | B_ALL);
        chk16(sf_count, 16'h0000);
        chk1(sf_q, 1'b0);
        q_m = 1'b0;
        cnt_m = 0;
        count_pulse(B_EN, 1);
        sf_apply(B_EN | B_SET);
        sf_apply(B_EN);
        q_m = 1'b1;
        power_cycle(1'b0, 1'b0);
        $display("test special inputs done");
        timer_case(relay_blocks_pkg::TB_SECONDS, 8'h00, 8'h03, 3);
        timer_case(relay_blocks_pkg::TB_SECONDS, 8'h01, 8'h00, 100);
        timer_case(relay_blocks_pkg::TB_MINUTES, 8'h00, 8'h01, 100);
        timer_case(relay_blocks_pkg::TB_HOURS, 8'h00, 8'h01, 6000);
        $display("test timebase done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire

// ==== testbench/upstream_blocks.sv ====
// upstream function blocks that feed the gate inputs, stable for whole program cycles
`timescale 1ns/10ps
`default_nettype none
module upstream_blocks (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [55:0] vec_in,
    output logic [55:0] vec_q
);
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            vec_q <= 56'h0;
        else if (load)
            vec_q <= vec_in;
    end
endmodule : upstream_blocks
`default_nettype wire
